/* File: inc/lsx_map.vh */
`ifndef LSX_MAP_VH
`define LSX_MAP_VH

// operation codes on the op_i port
`define LSX_OP_NOP 5'h00
`define LSX_OP_LOAD_INDIRECT 5'h01
`define LSX_OP_LOAD_POSTINC 5'h02
`define LSX_OP_LOAD_PREDEC 5'h03
`define LSX_OP_LOAD_DISPLACED 5'h04
`define LSX_OP_LOAD_DIRECT 5'h05
`define LSX_OP_STORE_INDIRECT 5'h06
`define LSX_OP_STORE_POSTINC 5'h07
`define LSX_OP_STORE_PREDEC 5'h08
`define LSX_OP_STORE_DISPLACED 5'h09
`define LSX_OP_STORE_DIRECT 5'h0A
`define LSX_OP_PUSH 5'h0B
`define LSX_OP_POP 5'h0C
`define LSX_OP_IO_BIT_SET 5'h0D
`define LSX_OP_IO_BIT_CLEAR 5'h0E
`define LSX_OP_SHIFT_LEFT_LOGICAL 5'h0F
`define LSX_OP_SHIFT_RIGHT_LOGICAL 5'h10
`define LSX_OP_ROTATE_LEFT_CARRY 5'h11
`define LSX_OP_ROTATE_RIGHT_CARRY 5'h12
`define LSX_OP_SHIFT_RIGHT_SIGNED 5'h13
`define LSX_OP_SWAP 5'h14
`define LSX_OP_BIT_TO_COPY_FLAG 5'h15
`define LSX_OP_COPY_FLAG_TO_BIT 5'h16
`define LSX_OP_FLAG_SET_GENERIC 5'h17
`define LSX_OP_FLAG_CLEAR_GENERIC 5'h18
`define LSX_OP_OVERFLOW_FLAG_SET 5'h19
`define LSX_OP_OVERFLOW_FLAG_CLEAR 5'h1A

// pointer select
`define LSX_PTR_FIRST 2'h0
`define LSX_PTR_SECOND 2'h1
`define LSX_PTR_THIRD 2'h2

// pointer pairs: low byte register index of each pair
`define LSX_PTR_FIRST_LO 5'h1A
`define LSX_PTR_SECOND_LO 5'h1C
`define LSX_PTR_THIRD_LO 5'h1E

// status register bit positions
`define LSX_FLAG_C 3'h0
`define LSX_FLAG_Z 3'h1
`define LSX_FLAG_N 3'h2
`define LSX_FLAG_V 3'h3
`define LSX_FLAG_S 3'h4
`define LSX_FLAG_H 3'h5
`define LSX_FLAG_T 3'h6
`define LSX_FLAG_I 3'h7

// reset values and cycle counts
`define LSX_STATUS_RST 8'h00
`define LSX_REG_RST 8'h00
`define LSX_SP_RST 16'h0000
`define LSX_CYC_MULTI 2'h2
`define LSX_CYC_FIRST 2'h1

`endif

/* File: hw/lsx_shift_unit.v */
`timescale 1ns/1ps
`include "lsx_map.vh"

// combinational shift, rotate and bit-copy unit
module lsx_shift_unit
(
	// operands
	input wire [4:0] op_i,
	input wire [7:0] val_i,
	input wire [2:0] bit_i,
	input wire [7:0] status_i,
	// result
	output reg [7:0] res_o,
	output reg [7:0] status_o
);

	reg c_new;
	reg upd;

	always @*
	begin
		res_o = val_i;
		status_o = status_i;
		c_new = status_i[`LSX_FLAG_C];
		upd = 1'b0;
		case (op_i)
			`LSX_OP_SHIFT_LEFT_LOGICAL:
			begin
				res_o = {val_i[6:0], 1'b0};
				c_new = val_i[7];
				upd = 1'b1;
			end
			`LSX_OP_SHIFT_RIGHT_LOGICAL:
			begin
				res_o = {1'b0, val_i[7:1]};
				c_new = val_i[0];
				upd = 1'b1;
			end
			`LSX_OP_ROTATE_LEFT_CARRY:
			begin
				res_o = {val_i[6:0], status_i[`LSX_FLAG_C]};
				c_new = val_i[7];
				upd = 1'b1;
			end
			`LSX_OP_ROTATE_RIGHT_CARRY:
			begin
				res_o = {status_i[`LSX_FLAG_C], val_i[7:1]};
				c_new = val_i[0];
				upd = 1'b1;
			end
			`LSX_OP_SHIFT_RIGHT_SIGNED:
			begin
				res_o = {val_i[7], val_i[7:1]};
				c_new = val_i[0];
				upd = 1'b1;
			end
			`LSX_OP_SWAP:
				res_o = {val_i[3:0], val_i[7:4]};
			`LSX_OP_BIT_TO_COPY_FLAG:
				status_o[`LSX_FLAG_T] = val_i[bit_i];
			`LSX_OP_COPY_FLAG_TO_BIT:
				res_o[bit_i] = status_i[`LSX_FLAG_T];
			default:
				res_o = val_i;
		endcase
		if (upd)
		begin
			// overflow is n xor c after the shift; sign follows n xor v
			status_o[`LSX_FLAG_C] = c_new;
			status_o[`LSX_FLAG_Z] = (res_o == 8'h00);
			status_o[`LSX_FLAG_N] = res_o[7];
			status_o[`LSX_FLAG_V] = res_o[7] ^ c_new;
			status_o[`LSX_FLAG_S] = c_new;
		end
	end

endmodule

/* File: hw/lsx_exec.v */
`timescale 1ns/1ps
`include "lsx_map.vh"

module lsx_exec
#(
	parameter NREG = 32
)
(
	// clock and reset
	input wire core_clk_i,
	input wire arst_n_i,
	// instruction issue
	input wire issue_i,
	input wire [4:0] op_i,
	input wire [4:0] reg_i,
	input wire [1:0] ptr_i,
	input wire [5:0] disp_i,
	input wire [15:0] addr_i,
	input wire [2:0] bit_i,
	input wire [5:0] io_addr_i,
	// data memory, stack and io space
	input wire [7:0] mem_rdata_i,
	output reg [15:0] mem_addr_o,
	output reg mem_rd_o,
	output reg mem_wr_o,
	output reg [7:0] mem_wdata_o,
	output reg io_rd_o,
	output reg io_wr_o,
	output reg [5:0] io_addr_o,
	// state
	output reg busy_o,
	output reg [7:0] status_o,
	output reg [15:0] sp_o
);

	localparam ST_IDLE = 1'b0;
	localparam ST_SECOND = 1'b1;

	reg [7:0] gpr_r [0:NREG-1];
	reg state_r;
	reg [4:0] op_r;
	reg [4:0] reg_r;
	reg [2:0] bit_r;
	reg [1:0] cyc_r;

	wire [7:0] shf_res;
	wire [7:0] shf_status;
	reg [4:0] plo;
	wire [15:0] ptr_val;
	wire [15:0] ptr_inc;
	wire [15:0] ptr_dec;
	wire [15:0] ptr_disp;
	wire is_multi;
	wire ptr_wr;
	wire [15:0] ptr_new;
	wire [1:0] cyc_nxt;
	wire last_cyc;
	wire ld_wb;
	wire iss;
	wire [7:0] io_mask;
	wire [7:0] io_mod;

	// ***************************
	// pointer pair selection
	// ***************************
	always @*
	begin
		case (ptr_i)
			`LSX_PTR_FIRST: plo = `LSX_PTR_FIRST_LO;
			`LSX_PTR_SECOND: plo = `LSX_PTR_SECOND_LO;
			default: plo = `LSX_PTR_THIRD_LO;
		endcase
	end

	assign ptr_val = {gpr_r[plo + 5'h01], gpr_r[plo]};
	assign ptr_inc = ptr_val + 16'h0001;
	assign ptr_dec = ptr_val - 16'h0001;
	assign ptr_disp = ptr_val + {10'h000, disp_i};

	assign is_multi = (op_i >= `LSX_OP_LOAD_INDIRECT) &&
		(op_i <= `LSX_OP_IO_BIT_CLEAR);
	assign ptr_wr = (op_i == `LSX_OP_LOAD_POSTINC) ||
		(op_i == `LSX_OP_LOAD_PREDEC) ||
		(op_i == `LSX_OP_STORE_POSTINC) ||
		(op_i == `LSX_OP_STORE_PREDEC);
	assign ptr_new = ((op_i == `LSX_OP_LOAD_POSTINC) ||
		(op_i == `LSX_OP_STORE_POSTINC)) ? ptr_inc : ptr_dec;
	assign iss = issue_i && !busy_o;

	// ***************************
	// cycle count and completion
	// ***************************
	// cyc_r holds cycles already spent, so the last cycle is where the
	// next count reaches the listed total
	assign cyc_nxt = cyc_r + `LSX_CYC_FIRST;
	assign last_cyc = (state_r == ST_SECOND) &&
		(cyc_nxt == `LSX_CYC_MULTI);
	// a load into the pointer's own register lands after the pointer
	// update, so the loaded byte wins
	assign ld_wb = last_cyc && (((op_r >= `LSX_OP_LOAD_INDIRECT) &&
		(op_r <= `LSX_OP_LOAD_DIRECT)) || (op_r == `LSX_OP_POP));
	// io bit set and clear modify the byte read back in the second cycle
	assign io_mask = 8'h01 << bit_r;
	assign io_mod = (op_r == `LSX_OP_IO_BIT_SET) ?
		(mem_rdata_i | io_mask) : (mem_rdata_i & ~io_mask);

	// ***************************
	// shift, rotate and bit-copy unit
	// ***************************
	lsx_shift_unit u_shift
	(
		.op_i(op_i),
		.val_i(gpr_r[reg_i]),
		.bit_i(bit_i),
		.status_i(status_o),
		.res_o(shf_res),
		.status_o(shf_status)
	);

	// ***************************
	// register file and pointers
	// ***************************
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi = gi + 1)
		begin : g_gpr
			always @(posedge core_clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					gpr_r[gi] <= `LSX_REG_RST;
				else if (ld_wb && reg_r == gi)
					gpr_r[gi] <= mem_rdata_i;
				else if (iss && ptr_wr && plo == gi)
					gpr_r[gi] <= ptr_new[7:0];
				else if (iss && ptr_wr && plo + 5'h01 == gi)
					gpr_r[gi] <= ptr_new[15:8];
				else if (iss && !is_multi && reg_i == gi)
					gpr_r[gi] <= shf_res;
			end
		end
	endgenerate

	// ***************************
	// sequencing and memory access
	// ***************************
	always @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_r <= ST_IDLE;
			op_r <= `LSX_OP_NOP;
			reg_r <= 5'h00;
			bit_r <= 3'h0;
			cyc_r <= 2'h0;
			busy_o <= 1'b0;
			mem_addr_o <= 16'h0000;
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			mem_wdata_o <= 8'h00;
			io_rd_o <= 1'b0;
			io_wr_o <= 1'b0;
			io_addr_o <= 6'h00;
			status_o <= `LSX_STATUS_RST;
			sp_o <= `LSX_SP_RST;
		end
		else
		begin
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			io_rd_o <= 1'b0;
			io_wr_o <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					if (issue_i)
					begin
						op_r <= op_i;
						reg_r <= reg_i;
						bit_r <= bit_i;
						mem_wdata_o <= gpr_r[reg_i];
						if (is_multi)
						begin
							state_r <= ST_SECOND;
							busy_o <= 1'b1;
							cyc_r <= `LSX_CYC_FIRST;
						end
						case (op_i)
							`LSX_OP_LOAD_INDIRECT, `LSX_OP_LOAD_POSTINC:
							begin
								mem_addr_o <= ptr_val;
								mem_rd_o <= 1'b1;
							end
							`LSX_OP_LOAD_PREDEC:
							begin
								mem_addr_o <= ptr_dec;
								mem_rd_o <= 1'b1;
							end
							`LSX_OP_LOAD_DISPLACED:
							begin
								mem_addr_o <= ptr_disp;
								mem_rd_o <= 1'b1;
							end
							`LSX_OP_LOAD_DIRECT:
							begin
								mem_addr_o <= addr_i;
								mem_rd_o <= 1'b1;
							end
							`LSX_OP_STORE_INDIRECT, `LSX_OP_STORE_POSTINC:
							begin
								mem_addr_o <= ptr_val;
								mem_wr_o <= 1'b1;
							end
							`LSX_OP_STORE_PREDEC:
							begin
								mem_addr_o <= ptr_dec;
								mem_wr_o <= 1'b1;
							end
							`LSX_OP_STORE_DISPLACED:
							begin
								mem_addr_o <= ptr_disp;
								mem_wr_o <= 1'b1;
							end
							`LSX_OP_STORE_DIRECT:
							begin
								mem_addr_o <= addr_i;
								mem_wr_o <= 1'b1;
							end
							`LSX_OP_PUSH:
							begin
								// post-decrement stack: write then move down
								mem_addr_o <= sp_o;
								mem_wr_o <= 1'b1;
								sp_o <= sp_o - 16'h0001;
							end
							`LSX_OP_POP:
							begin
								mem_addr_o <= sp_o + 16'h0001;
								mem_rd_o <= 1'b1;
								sp_o <= sp_o + 16'h0001;
							end
							`LSX_OP_IO_BIT_SET, `LSX_OP_IO_BIT_CLEAR:
							begin
								// read-modify-write over two cycles
								io_addr_o <= io_addr_i;
								io_rd_o <= 1'b1;
							end
							`LSX_OP_FLAG_SET_GENERIC:
								status_o[bit_i] <= 1'b1;
							`LSX_OP_FLAG_CLEAR_GENERIC:
								status_o[bit_i] <= 1'b0;
							`LSX_OP_OVERFLOW_FLAG_SET:
								status_o[`LSX_FLAG_V] <= 1'b1;
							`LSX_OP_OVERFLOW_FLAG_CLEAR:
								status_o[`LSX_FLAG_V] <= 1'b0;
							default:
								status_o <= shf_status;
						endcase
					end
				end
				ST_SECOND:
				begin
					cyc_r <= cyc_nxt;
					if (last_cyc)
					begin
						if (op_r == `LSX_OP_IO_BIT_SET ||
							op_r == `LSX_OP_IO_BIT_CLEAR)
						begin
							mem_wdata_o <= io_mod;
							io_wr_o <= 1'b1;
						end
						state_r <= ST_IDLE;
						busy_o <= 1'b0;
					end
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

endmodule

/* File: tb/lsx_exec_asserts.sv */
`timescale 1ns/1ps
`include "lsx_map.vh"
// ****************
// execution checker
// ****************
module lsx_exec_asserts
(
	// clock and reset
	input wire core_clk_i,
	input wire arst_n_i,
	// issue side
	input wire issue_i,
	input wire [4:0] op_i,
	input wire [15:0] addr_i,
	input wire [2:0] bit_i,
	input wire [5:0] io_addr_i,
	input wire [7:0] mem_rdata_i,
	// memory, io and state
	input wire [15:0] mem_addr_o,
	input wire mem_rd_o,
	input wire mem_wr_o,
	input wire [7:0] mem_wdata_o,
	input wire io_rd_o,
	input wire io_wr_o,
	input wire [5:0] io_addr_o,
	input wire busy_o,
	input wire [7:0] status_o,
	input wire [15:0] sp_o
);
	wire tk = issue_i && !busy_o;
	wire multi = tk && op_i >= `LSX_OP_LOAD_INDIRECT
		&& op_i <= `LSX_OP_IO_BIT_CLEAR;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence io_rd_s;
		io_rd_o && io_addr_o == $past(io_addr_i);
	endsequence
	busy_len_a: assert property (multi |=> busy_o ##1 !busy_o)
		else $error("busy length wrong");
	keep_flags_a: assert property (multi |=> $stable(status_o) [*2])
		else $error("flags moved by memory op");
	direct_load_a: assert property (tk && op_i == `LSX_OP_LOAD_DIRECT
		|=> mem_rd_o && mem_addr_o == $past(addr_i) ##1 !mem_rd_o)
		else $error("direct load address wrong");
	direct_store_a: assert property (tk && op_i == `LSX_OP_STORE_DIRECT
		|=> mem_wr_o && mem_addr_o == $past(addr_i) ##1 !mem_wr_o)
		else $error("direct store address wrong");
	push_sp_a: assert property (tk && op_i == `LSX_OP_PUSH
		|=> mem_wr_o && mem_addr_o == $past(sp_o)
		##1 sp_o == $past(sp_o, 2) - 16'h0001) else $error("push wrong");
	io_set_a: assert property (tk && op_i == `LSX_OP_IO_BIT_SET
		|=> io_rd_s ##1 (io_wr_o && mem_wdata_o ==
		($past(mem_rdata_i) | (8'h01 << $past(bit_i, 2))))) else $error("io set");
	io_clr_a: assert property (tk && op_i == `LSX_OP_IO_BIT_CLEAR
		|=> io_rd_s ##1 (io_wr_o && mem_wdata_o ==
		($past(mem_rdata_i) & ~(8'h01 << $past(bit_i, 2))))) else $error("io clr");
	gen_set_a: assert property (tk && op_i == `LSX_OP_FLAG_SET_GENERIC
		|=> status_o == ($past(status_o) | (8'h01 << $past(bit_i))))
		else $error("generic flag set wrong");
	copy_only_a: assert property (tk && op_i == `LSX_OP_BIT_TO_COPY_FLAG
		|=> (status_o & 8'hBF) == ($past(status_o) & 8'hBF))
		else $error("copy flag touched other flags");
endmodule
bind lsx_exec lsx_exec_asserts chk_i (.core_clk_i, .arst_n_i, .issue_i,
	.op_i, .addr_i, .bit_i, .io_addr_i, .mem_rdata_i, .mem_addr_o, .mem_rd_o,
	.mem_wr_o, .mem_wdata_o, .io_rd_o, .io_wr_o, .io_addr_o, .busy_o,
	.status_o, .sp_o);

/* File: tb/lsx_mem_model.sv */
`timescale 1ns/1ps
// ****************
// data memory and io model
// ****************
module lsx_mem_model
(
	// clock
	input wire core_clk_i,
	// access
	input wire [15:0] mem_addr_o,
	input wire mem_rd_o,
	input wire mem_wr_o,
	input wire [7:0] mem_wdata_o,
	input wire io_rd_o,
	input wire io_wr_o,
	input wire [5:0] io_addr_o,
	// read data
	output logic [7:0] mem_rdata_i
);
	logic [7:0] mem [0:255];
	logic [7:0] io [0:63];
	logic [7:0] last;
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		for (int j = 0; j < 64; j++)
			io[j] = 8'hA0;
		last = 8'h00;
	end
	always @(posedge core_clk_i)
	begin
		if (mem_wr_o)
			mem[mem_addr_o[7:0]] <= mem_wdata_o;
		if (io_wr_o)
			io[io_addr_o] <= mem_wdata_o;
		last <= mem_rdata_i;
	end
	// idle bus toggles so a stale sample never looks valid
	always @*
		mem_rdata_i = mem_rd_o ? mem[mem_addr_o[7:0]] :
			io_rd_o ? io[io_addr_o] : ~last;
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "lsx_map.vh"
module tb;
	logic core_clk_i = 1'b0, arst_n_i = 1'b0, issue_i = 1'b0;
	logic [4:0] op_i = 5'h00, reg_i = 5'h00;
	logic [1:0] ptr_i = 2'h0;
	logic [5:0] disp_i = 6'h00, io_addr_i = 6'h00;
	logic [15:0] addr_i = 16'h0000, ma;
	logic [2:0] bit_i = 3'h0;
	logic [7:0] wd, st;
	wire [7:0] mem_rdata_i, mem_wdata_o, status_o;
	wire [15:0] mem_addr_o, sp_o;
	wire [5:0] io_addr_o;
	wire mem_rd_o, mem_wr_o, io_rd_o, io_wr_o, busy_o;
	int bad_count = 0, total_checks = 0, cyc = 0;
	logic [4:0] sh_op [7] = '{`LSX_OP_SHIFT_LEFT_LOGICAL,
		`LSX_OP_ROTATE_LEFT_CARRY, `LSX_OP_ROTATE_RIGHT_CARRY,
		`LSX_OP_ROTATE_RIGHT_CARRY, `LSX_OP_SHIFT_RIGHT_SIGNED,
		`LSX_OP_SHIFT_RIGHT_LOGICAL, `LSX_OP_SWAP};
	logic [7:0] sh_v [7] = '{8'h02, 8'h05, 8'h02, 8'h81, 8'hC0, 8'h60, 8'h06};
	logic [3:0] sh_f [7] = '{4'h9, 4'h0, 4'h9, 4'hC, 4'h5, 4'h0, 4'h0};
	always #2.5 core_clk_i = ~core_clk_i;
	lsx_exec uut (.core_clk_i, .arst_n_i, .issue_i, .op_i, .reg_i, .ptr_i,
		.disp_i, .addr_i, .bit_i, .io_addr_i, .mem_rdata_i, .mem_addr_o,
		.mem_rd_o, .mem_wr_o, .mem_wdata_o, .io_rd_o, .io_wr_o, .io_addr_o,
		.busy_o, .status_o, .sp_o);
	lsx_mem_model mem_m (.core_clk_i, .mem_addr_o, .mem_rd_o, .mem_wr_o,
		.mem_wdata_o, .io_rd_o, .io_wr_o, .io_addr_o, .mem_rdata_i);
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
	begin
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	end
	endtask
	// field packing: ptr 7:6, disp and io 5:0, bit 10:8
	task op(input logic [4:0] o, input logic [4:0] r, input logic [15:0] a);
	begin
		op_i = o;
		reg_i = r;
		addr_i = a;
		disp_i = a[5:0];
		io_addr_i = a[5:0];
		ptr_i = a[7:6];
		bit_i = a[10:8];
		// issue stays high: a request offered while busy is refused
		issue_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		ma = mem_addr_o;
		wd = mem_wdata_o;
		chk("busy", {15'h0, busy_o}, {15'h0, o >= `LSX_OP_LOAD_INDIRECT &&
			o <= `LSX_OP_IO_BIT_CLEAR});
		if (busy_o === 1'b1)
		begin
			@(posedge core_clk_i);
			#1;
			chk("busy_end", {15'h0, busy_o}, 16'h0000);
		end
	end
	endtask
	task see(input logic [4:0] r, input logic [7:0] e);
	begin
		op(`LSX_OP_STORE_DIRECT, r, 16'h0080);
		chk("reg", {8'h00, wd}, {8'h00, e});
	end
	endtask
	task summarize;
	begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			bad_count++;
			summarize;
		end
	end
	initial
	begin
		repeat (10) @(posedge core_clk_i);
		#1 arst_n_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		chk("rst_busy", {15'h0, busy_o}, 16'h0000);
		chk("rst_sp", sp_o, 16'h0000);
		op(`LSX_OP_LOAD_DIRECT, 5'd0, 16'h0010);
		chk("ld_addr", ma, 16'h0010);
		see(5'd0, 8'h4A);
		chk("st_addr", ma, 16'h0080);
		op(`LSX_OP_LOAD_DIRECT, 5'd28, 16'h00A5);
		op(`LSX_OP_LOAD_DIRECT, 5'd29, 16'h005A);
		op(`LSX_OP_LOAD_POSTINC, 5'd1, 16'h0040);
		chk("postinc", ma, 16'h00FF);
		op(`LSX_OP_LOAD_INDIRECT, 5'd2, 16'h0040);
		chk("ptr_carry", ma, 16'h0100);
		op(`LSX_OP_LOAD_PREDEC, 5'd3, 16'h0040);
		chk("predec", ma, 16'h00FF);
		op(`LSX_OP_LOAD_DISPLACED, 5'd3, 16'h0045);
		chk("ld_disp", ma, 16'h0104);
		see(5'd3, 8'h5E);
		see(5'd1, 8'hA5);
		op(`LSX_OP_LOAD_DIRECT, 5'd26, 16'h0030);
		op(`LSX_OP_LOAD_DIRECT, 5'd27, 16'h005A);
		op(`LSX_OP_STORE_POSTINC, 5'd0, 16'h0000);
		chk("st_inc", ma, 16'h006A);
		chk("st_data", {8'h00, wd}, 16'h004A);
		op(`LSX_OP_STORE_PREDEC, 5'd0, 16'h0000);
		chk("st_dec", ma, 16'h006A);
		op(`LSX_OP_STORE_DISPLACED, 5'd0, 16'h0041);
		chk("st_disp", ma, 16'h0100);
		op(`LSX_OP_PUSH, 5'd1, 16'h0000);
		chk("sp_push", sp_o, 16'hFFFF);
		op(`LSX_OP_POP, 5'd4, 16'h0000);
		chk("sp_pop", sp_o, 16'h0000);
		see(5'd4, 8'hA5);
		op(`LSX_OP_IO_BIT_SET, 5'd0, 16'h0103);
		op(`LSX_OP_IO_BIT_CLEAR, 5'd0, 16'h0704);
		issue_i = 1'b0;
		@(posedge core_clk_i);
		#1;
		chk("io_set", {8'h00, mem_m.io[3]}, 16'h00A2);
		chk("io_clr", {8'h00, mem_m.io[4]}, 16'h0020);
		$display("memory tests done");
		op(`LSX_OP_LOAD_DIRECT, 5'd5, 16'h00DB);
		for (int i = 0; i < 7; i++)
		begin
			op(sh_op[i], 5'd5, 16'h0000);
			chk("shf", {12'h000, status_o[3:0]}, {12'h000, sh_f[i]});
			see(5'd5, sh_v[i]);
		end
		$display("shift tests done");
		op(`LSX_OP_BIT_TO_COPY_FLAG, 5'd5, 16'h0100);
		chk("tflag", {8'h00, status_o}, 16'h0040);
		op(`LSX_OP_COPY_FLAG_TO_BIT, 5'd0, 16'h0000);
		see(5'd0, 8'h4B);
		st = 8'h40;
		for (int b = 0; b < 16; b++)
		begin
			st[b % 8] = (b < 8);
			op(b < 8 ? `LSX_OP_FLAG_SET_GENERIC : `LSX_OP_FLAG_CLEAR_GENERIC,
				5'd0, {5'h00, b[2:0], 8'h00});
			chk("flag", {8'h00, status_o}, {8'h00, st});
		end
		op(`LSX_OP_OVERFLOW_FLAG_SET, 5'd0, 16'h0000);
		chk("ovf_set", {8'h00, status_o}, 16'h0008);
		op(`LSX_OP_OVERFLOW_FLAG_CLEAR, 5'd0, 16'h0000);
		chk("ovf_clr", {8'h00, status_o}, 16'h0000);
		$display("flag tests done");
		op(`LSX_OP_FLAG_SET_GENERIC, 5'd0, 16'h0700);
		op(`LSX_OP_PUSH, 5'd0, 16'h0000);
		issue_i = 1'b0;
		arst_n_i = 1'b0;
		@(posedge core_clk_i);
		#1 arst_n_i = 1'b1;
		chk("rst_sp", sp_o, 16'h0000);
		chk("rst_st", {8'h00, status_o}, 16'h0000);
		see(5'd5, 8'h00);
		$display("reset tests done");
		summarize;
	end
endmodule
